// ---- mgmt_device.sv ----
// mgmt_device: management slave with 32 direct registers and an indirect extended window
// assumes: the station drives the clock; SYS_CLK samples the clock and data pins
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
module mgmt_device
  import mgmt_pkg::*;
#(
  parameter int EXT_WORDS = EXT_DEPTH
) (
  // system
  input  wire logic                        SYS_CLK,
  input  wire logic                        RESET_N,
  // straps
  input  wire logic [mgmt_pkg::ADDR_W-1:0] BUS_ADDRESS_STRAPS,
  // link
  mgmt_if.device                           LINK,
  // status
  output logic [mgmt_pkg::ADDR_W-1:0]      BUS_ADDRESS,
  output logic [mgmt_pkg::DATA_W-1:0]      CTRL_VALUE,
  output logic [mgmt_pkg::DATA_W-1:0]      POINTER_VALUE
);
  import mgmt_pkg::*;

  initial begin
    if (EXT_WORDS < 2 || EXT_WORDS > 65536) $error("EXT_WORDS out of range");
  end

  localparam int EW = $clog2(EXT_WORDS);

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_HDR   = 3'b001,
    S_TA    = 3'b011,
    S_DATA  = 3'b010,
    S_SKIP  = 3'b110
  } dev_state_t;

  // pin synchronisers
  logic [1:0] mdc_sync_q;
  logic [1:0] mdio_sync_q;
  logic       mdc_prev_q;
  logic       rise;
  logic       fall;
  logic       bit_in;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mdc_sync_q  <= 2'h0;
      mdio_sync_q <= 2'h3;
      mdc_prev_q  <= 1'b0;
    end else begin
      mdc_sync_q  <= {mdc_sync_q[0], LINK.mdc};
      mdio_sync_q <= {mdio_sync_q[0], LINK.mdio_i};
      mdc_prev_q  <= mdc_sync_q[1];
    end
  end

  assign rise   = mdc_sync_q[1] & ~mdc_prev_q;
  assign fall   = ~mdc_sync_q[1] & mdc_prev_q;
  assign bit_in = mdio_sync_q[1];

  // strap capture one cycle after reset release
  logic strap_done_q;
  logic [ADDR_W-1:0] addr_q;
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_done_q <= 1'b0;
      addr_q       <= '0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      addr_q       <= BUS_ADDRESS_STRAPS;
    end
  end
  assign BUS_ADDRESS = addr_q;

  // frame receiver; state only moves on clock edges, so a stopped clock just waits
  dev_state_t         state_q;
  logic [5:0]         cnt_q;
  logic [HDR_BITS-1:0] hdr_q;
  logic [DATA_W-1:0]  shift_q;
  logic               is_read_q;
  logic               hdr_done;
  logic [1:0]         op_f;
  logic [4:0]         phy_f;
  logic [4:0]         reg_f;
  logic               do_write;

  // last register address bit: start bit plus twelve header bits
  assign hdr_done = (state_q == S_HDR) && rise && (cnt_q == 6'(HDR_BITS - 2));
  assign op_f     = hdr_q[11:10];
  assign phy_f    = hdr_q[9:5];
  assign reg_f    = hdr_q[4:0];

  logic [HDR_BITS-1:0] hdr_n;
  assign hdr_n = {hdr_q[HDR_BITS-2:0], bit_in};

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_q   <= S_IDLE;
      cnt_q     <= 6'h00;
      hdr_q     <= '0;
      is_read_q <= 1'b0;
    end else if (rise) begin
      case (state_q)
        S_IDLE: begin
          // zero bit after idle ones: first half of start code
          if (!bit_in && strap_done_q) begin
            state_q <= S_HDR;
            cnt_q   <= 6'h00;
            hdr_q   <= '0;
          end
        end
        S_HDR: begin
          hdr_q <= hdr_n;
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == 6'h00 && !bit_in) begin
            state_q <= S_IDLE;
          end else if (cnt_q == 6'(HDR_BITS - 2)) begin
            cnt_q <= 6'h00;
            if (hdr_n[9:5] == addr_q && (hdr_n[11:10] == OP_READ
                || hdr_n[11:10] == OP_WRITE)) begin
              is_read_q <= (hdr_n[11:10] == OP_READ);
              state_q   <= S_TA;
            end else begin
              state_q <= S_SKIP;
            end
          end
        end
        S_TA: begin
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == 6'h01) begin
            cnt_q   <= 6'h00;
            state_q <= S_DATA;
          end
        end
        S_DATA: begin
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == 6'(DATA_W - 1)) begin
            state_q <= S_IDLE;
          end
        end
        S_SKIP: begin
          cnt_q <= cnt_q + 6'h01;
          if (cnt_q == 6'(DATA_W + 1)) begin
            state_q <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  assign do_write = rise && state_q == S_DATA && !is_read_q && cnt_q == 6'(DATA_W - 1);

  // register storage
  logic [DATA_W-1:0] regs_q [NUM_REGS];
  logic [DATA_W-1:0] ext_q  [EXT_WORDS];
  logic [DATA_W-1:0] ctrl_q;
  logic [DATA_W-1:0] ptr_q;
  logic [4:0]        dev_f;
  logic [1:0]        fn_f;
  logic              dev_ok;
  logic              ptr_std;
  logic [DATA_W-1:0] wdata;

  assign dev_f  = ctrl_q[CTRL_DEV_LSB +: 5];
  assign fn_f   = ctrl_q[CTRL_FN_LSB +: 2];
  assign dev_ok = (dev_f == DEV_VENDOR) || (dev_f == DEV_EEE_A)
                  || (dev_f == DEV_EEE_B);
  // vendor space low addresses alias the standard set, window regs excluded
  assign ptr_std = (dev_f == DEV_VENDOR) && (ptr_q < 16'(NUM_REGS));
  assign wdata  = {shift_q[DATA_W-2:0], bit_in};

  logic win_data;
  logic std_hit;
  assign win_data = dev_ok && fn_f != FN_ADDR;
  assign std_hit  = ptr_std && ptr_q[4:0] != REG_CTRL && ptr_q[4:0] != REG_WINDOW;

  function automatic logic [DATA_W-1:0] rd_word(input logic [4:0] r);
    logic [DATA_W-1:0] v;
    v = regs_q[r];
    if (r == REG_CTRL) v = ctrl_q;
    else if (r == REG_WINDOW) begin
      if (!dev_ok) v = '0;
      else if (fn_f == FN_ADDR) v = ptr_q;
      else if (std_hit) v = regs_q[ptr_q[4:0]];
      else if (ptr_std) v = '0;
      else v = ext_q[ptr_q[EW-1:0]];
    end
    return v;
  endfunction : rd_word

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_q <= CTRL_RESET;
      ptr_q  <= PTR_RESET;
    end else begin
      if (do_write && reg_f == REG_CTRL) ctrl_q <= wdata;
      if (do_write && reg_f == REG_WINDOW && dev_ok) begin
        if (fn_f == FN_ADDR) ptr_q <= wdata;
        else if (fn_f == FN_DATA_INC || fn_f == FN_DATA_INC_WR) ptr_q <= ptr_q + 16'h0001;
      end
      if (rise && state_q == S_DATA && is_read_q && cnt_q == 6'(DATA_W - 1)
          && reg_f == REG_WINDOW && dev_ok && fn_f == FN_DATA_INC) begin
        ptr_q <= ptr_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (do_write && reg_f != REG_CTRL && reg_f != REG_WINDOW) begin
      regs_q[reg_f] <= wdata;
    end
    if (do_write && reg_f == REG_WINDOW && win_data) begin
      if (std_hit) regs_q[ptr_q[4:0]] <= wdata;
      else if (!ptr_std) ext_q[ptr_q[EW-1:0]] <= wdata;
    end
  end

  // data shifter and driver: drive starts and data changes after the clock falls; release follows the last data rise
  logic drv_q;
  logic out_q;
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      shift_q <= '0;
      drv_q   <= 1'b0;
      out_q   <= 1'b1;
    end else begin
      // reads shift only on falls, writes only on rises
      if (rise && state_q == S_DATA && !is_read_q) shift_q <= wdata;
      if (hdr_done) shift_q <= rd_word(hdr_n[4:0]);
      if (fall) begin
        if (state_q == S_TA && is_read_q && cnt_q == 6'h01) begin
          drv_q <= 1'b1;
          out_q <= 1'b0;
        end else if (state_q == S_DATA && is_read_q) begin
          drv_q   <= 1'b1;
          out_q   <= shift_q[DATA_W-1];
          shift_q <= {shift_q[DATA_W-2:0], 1'b0};
        end else begin
          drv_q <= 1'b0;
          out_q <= 1'b1;
        end
      end
      if (state_q == S_IDLE || state_q == S_SKIP) drv_q <= 1'b0;
    end
  end

  assign LINK.dev_mdio_o  = out_q;
  assign LINK.dev_mdio_oe = drv_q;
  assign CTRL_VALUE       = ctrl_q;
  assign POINTER_VALUE    = ptr_q;
endmodule : mgmt_device

// ---- mgmt_pkg.sv ----
// mgmt_pkg: shared constants for the serial management link and its indirect window
// assumes: included before the interface and both end modules
package mgmt_pkg;
  localparam int          ADDR_W         = 5;
  localparam int          DATA_W         = 16;
  localparam int          NUM_REGS       = 32;
  localparam logic [1:0]  START_CODE     = 2'h1;
  localparam logic [1:0]  OP_READ        = 2'h2;
  localparam logic [1:0]  OP_WRITE       = 2'h1;
  localparam logic [1:0]  TA_WRITE       = 2'h2;
  localparam int          HDR_BITS       = 14;
  localparam int          FRAME_BITS     = 32;
  localparam logic [4:0]  REG_CTRL       = 5'h0d;
  localparam logic [4:0]  REG_WINDOW     = 5'h0e;
  localparam int          CTRL_DEV_LSB   = 0;
  localparam int          CTRL_FN_LSB    = 14;
  localparam logic [4:0]  DEV_VENDOR     = 5'h1f;
  localparam logic [4:0]  DEV_EEE_A      = 5'h03;
  localparam logic [4:0]  DEV_EEE_B      = 5'h07;
  localparam logic [1:0]  FN_ADDR        = 2'h0;
  localparam logic [1:0]  FN_DATA        = 2'h1;
  localparam logic [1:0]  FN_DATA_INC    = 2'h2;
  localparam logic [1:0]  FN_DATA_INC_WR = 2'h3;
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] PTR_RESET      = 16'h0000;
  localparam int          EXT_DEPTH      = 64;
  // bench-side clock figures
  localparam int          SYS_PERIOD_NS  = 50;
  localparam int          MDC_MIN_NS     = 40;
  localparam int          MDC_HALF_CYC   = (MDC_MIN_NS + 2 * SYS_PERIOD_NS - 1) / (2 * SYS_PERIOD_NS);
  localparam int          IDLE_AFTER_RST = 1;
endpackage : mgmt_pkg

// ---- mgmt_if.sv ----
// mgmt_if: the two-wire management link between station and device
// assumes: the bench resolves the data wire from the two enables with a pull-up
`timescale 1ns/1ns
interface mgmt_if;
  logic mdc;
  logic sta_mdio_o;
  logic sta_mdio_oe;
  logic dev_mdio_o;
  logic dev_mdio_oe;
  logic mdio_i;
  modport station (output mdc, output sta_mdio_o, output sta_mdio_oe, input mdio_i);
  modport device  (input mdc, output dev_mdio_o, output dev_mdio_oe, input mdio_i);
endinterface : mgmt_if

// ---- mgmt_station.sv ----
// mgmt_station: management master driving clock and frames, ordered via a small register port
// assumes: the device end shares the link interface; software uses the plain strobe port
`timescale 1ns/1ns
module mgmt_station
  import mgmt_pkg::*;
#(
  parameter int HALF_CYC = MDC_HALF_CYC
) (
  // system
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  // register port
  input  wire logic [1:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [15:0]      RDATA,
  // link
  mgmt_if.station          LINK
);
  import mgmt_pkg::*;

  initial begin
    if (HALF_CYC < 4) $error("HALF_CYC must be at least 4");
  end

  localparam logic [1:0] A_CMD = 2'h0;
  localparam logic [1:0] A_WDATA = 2'h1;
  localparam logic [1:0] A_RDATA = 2'h2;
  localparam logic [1:0] A_STAT = 2'h3;

  logic [15:0] cmd_q;
  logic [15:0] wd_q;
  logic [15:0] rd_q;
  logic        busy_q;
  logic        go;
  logic [1:0]  din_sync_q;
  logic        mdc_q;
  logic [7:0]  div_q;
  logic [5:0]  bit_q;
  logic [FRAME_BITS+1:0] frame_q;
  logic        rdop_q;
  logic        idle_done_q;
  logic        tick;
  logic [1:0]  samp_q;

  // cmd: [12] read, [9:5] bus address, [4:0] register; writing it starts a frame
  assign go   = WR && ADDR == A_CMD && !busy_q && idle_done_q;
  assign tick = div_q == 8'(HALF_CYC - 1);

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cmd_q <= 16'h0000;
      wd_q  <= 16'h0000;
    end else begin
      if (go) cmd_q <= WDATA;
      if (WR && ADDR == A_WDATA) wd_q <= WDATA;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= 16'h0000;
    end else if (RD) begin
      case (ADDR)
        A_CMD:   RDATA <= cmd_q;
        A_WDATA: RDATA <= wd_q;
        A_RDATA: RDATA <= rd_q;
        A_STAT:  RDATA <= {15'h0000, busy_q};
        default: RDATA <= 16'h0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) din_sync_q <= 2'h3;
    else din_sync_q <= {din_sync_q[0], LINK.mdio_i};
  end

  // rise marker delayed by the input synchroniser depth
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) samp_q <= 2'h0;
    else samp_q <= {samp_q[0], busy_q && tick && !mdc_q};
  end

  // clock divider; the clock runs only during frames
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_q       <= 8'h00;
      mdc_q       <= 1'b0;
      bit_q       <= 6'h00;
      busy_q      <= 1'b0;
      frame_q     <= '1;
      rdop_q      <= 1'b0;
      rd_q        <= 16'h0000;
      idle_done_q <= 1'b0;
    end else begin
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      if (tick && !busy_q && !mdc_q) idle_done_q <= 1'b1;
      if (go) begin
        busy_q  <= 1'b1;
        rdop_q  <= WDATA[12];
        bit_q   <= 6'h00;
        div_q   <= 8'h00;
        // one leading idle bit, start, opcode, address, register, turnaround, data
        frame_q <= {1'b1, START_CODE, WDATA[12] ? OP_READ : OP_WRITE, WDATA[9:5],
                    WDATA[4:0], WDATA[12] ? 2'h3 : TA_WRITE, wd_q, 1'b1};
      end else if (busy_q && tick) begin
        mdc_q <= ~mdc_q;
        if (mdc_q) begin
          frame_q <= {frame_q[FRAME_BITS:0], 1'b1};
          bit_q   <= bit_q + 6'h01;
          if (bit_q == 6'(FRAME_BITS)) busy_q <= 1'b0;
        end
      end
      // line as it stood at the rise; device answers a few cycles after the fall
      if (samp_q[1] && rdop_q && bit_q > 6'(HDR_BITS + 2) && bit_q <= 6'(FRAME_BITS)) begin
        rd_q <= {rd_q[14:0], din_sync_q[1]};
      end
    end
  end

  // release the line for turnaround and data on reads
  logic drive;
  assign drive = busy_q && !(rdop_q && bit_q > 6'(HDR_BITS));

  assign LINK.mdc         = mdc_q;
  assign LINK.sta_mdio_o  = frame_q[FRAME_BITS+1];
  assign LINK.sta_mdio_oe = drive;
endmodule : mgmt_station

// ---- mgmt_link_monitor.sv ----
// mgmt_link_monitor: protocol checks on the shared management link
// assumes: station link clock half period of four system cycles
`timescale 1ns/1ns
module mgmt_link_monitor (
  // system
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // link
  input wire logic mdc,
  input wire logic sta_mdio_o,
  input wire logic sta_mdio_oe,
  input wire logic dev_mdio_o,
  input wire logic dev_mdio_oe,
  input wire logic mdio_i
);
  logic       mdc_q;
  logic [5:0] sta_bit_q;
  logic [5:0] dev_bit_q;
  logic       rise;

  assign rise = mdc & ~mdc_q;

  // link clock rises counted while each end drives
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mdc_q     <= 1'b0;
      sta_bit_q <= 6'h0;
      dev_bit_q <= 6'h0;
    end else begin
      mdc_q     <= mdc;
      sta_bit_q <= sta_mdio_oe ? sta_bit_q + {5'h0, rise} : 6'h0;
      dev_bit_q <= dev_mdio_oe ? dev_bit_q + {5'h0, rise} : 6'h0;
    end
  end

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);

  sequence s_bit(int n);
    rise && sta_mdio_oe && sta_bit_q == n;
  endsequence

  AST_NO_CLASH: assert property (!(sta_mdio_oe && dev_mdio_oe))
    else $error("both ends drive the data line");
  AST_IDLE_START: assert property ($rose(RESET_N) |-> (!mdc && !sta_mdio_oe)[*4])
    else $error("link active right after reset");
  AST_START_CODE: assert property (s_bit(1) |-> !mdio_i ##8 (s_bit(2) ##0 mdio_i))
    else $error("start code not zero then one");
  AST_WRITE_TA: assert property (s_bit(15) |-> mdio_i ##8 (s_bit(16) ##0 !mdio_i))
    else $error("write turnaround not one then zero");
  AST_STA_HOLD: assert property (rise && sta_mdio_oe |=> $stable(sta_mdio_o)[*3])
    else $error("station data moved after clock rise");
  AST_DEV_HOLD: assert property (rise && dev_mdio_oe |=> $stable(dev_mdio_o)[*2])
    else $error("device data moved after clock rise");
  AST_TA_FREE: assert property ($fell(sta_mdio_oe) |-> (!dev_mdio_oe)[*4])
    else $error("device drives in first turnaround bit");
  AST_TA_ZERO: assert property ($rose(dev_mdio_oe) |-> !dev_mdio_o)
    else $error("device turnaround bit not zero");
  AST_DEV_BITS: assert property ($fell(dev_mdio_oe) |-> dev_bit_q == 6'h11)
    else $error("device drove wrong number of bits");
endmodule : mgmt_link_monitor

// ---- testbench.sv ----
// testbench: station and device joined on one link, driven over the station register port
// assumes: pull-up on the data wire; station link clock of 400 ns
`timescale 1ns/1ns
module testbench;
  import mgmt_pkg::*;
  localparam logic [4:0] ME = 5'h0b;
  logic        sys_clk;
  logic        reset_n;
  logic [1:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [4:0]  bus_address;
  logic [15:0] ctrl_value;
  logic [15:0] pointer_value;
  logic [15:0] q;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;

  mgmt_if link ();
  // wired line with pull-up
  assign link.mdio_i = ~((link.sta_mdio_oe & ~link.sta_mdio_o)
                       | (link.dev_mdio_oe & ~link.dev_mdio_o));

  mgmt_station #(.HALF_CYC(4)) mgmt_station_inst (.SYS_CLK(sys_clk), .RESET_N(reset_n),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .LINK(link));
  mgmt_device mgmt_device_inst (.SYS_CLK(sys_clk), .RESET_N(reset_n),
    .BUS_ADDRESS_STRAPS(ME), .LINK(link), .BUS_ADDRESS(bus_address),
    .CTRL_VALUE(ctrl_value), .POINTER_VALUE(pointer_value));
  mgmt_link_monitor mgmt_link_monitor_inst (.SYS_CLK(sys_clk), .RESET_N(reset_n),
    .mdc(link.mdc), .sta_mdio_o(link.sta_mdio_o), .sta_mdio_oe(link.sta_mdio_oe),
    .dev_mdio_o(link.dev_mdio_o), .dev_mdio_oe(link.dev_mdio_oe), .mdio_i(link.mdio_i));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 40000) begin
      num_errors++;
      report_and_stop;
    end
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic port_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : port_wr

  task automatic port_rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(posedge sys_clk);
    d = rdata;
  endtask : port_rd

  // one frame through the station, result left in r
  task automatic frame(input logic rd_op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] d, output logic [15:0] r);
    logic [15:0] s;
    int          n;
    n = 0;
    port_wr(2'h1, d);
    port_wr(2'h0, {3'h0, rd_op, 2'h0, pa, ra});
    do begin
      port_rd(2'h3, s);
      n++;
    end while (s[0] !== 1'b0 && n < 200);
    chk("busy", 16'h0000, {15'h0, s[0]});
    // device sees the last bit a few cycles late
    repeat (4) @(posedge sys_clk);
    port_rd(2'h2, r);
  endtask : frame

  task automatic put(input logic [4:0] ra, input logic [15:0] d);
    frame(1'b0, ME, ra, d, q);
  endtask : put

  task automatic get(input logic [4:0] ra);
    frame(1'b1, ME, ra, 16'h0000, q);
  endtask : get

  task automatic aim(input logic [1:0] fn, input logic [4:0] sp, input logic [15:0] p);
    put(REG_CTRL, {FN_ADDR, 9'h0, sp});
    put(REG_WINDOW, p);
    put(REG_CTRL, {fn, 9'h0, sp});
  endtask : aim

  task automatic t_direct;
    logic [4:0] regs [2] = '{5'h00, 5'h1f};
    chk("bus_address", {11'h0, ME}, {11'h0, bus_address});
    chk("ptr", PTR_RESET, pointer_value);
    foreach (regs[i]) begin
      put(regs[i], {regs[i], 11'h2a5});
      get(regs[i]);
      chk("direct", {regs[i], 11'h2a5}, q);
    end
    frame(1'b0, ME ^ 5'h01, 5'h1f, 16'hdead, q);
    get(5'h1f);
    chk("foreign_wr", {5'h1f, 11'h2a5}, q);
    frame(1'b1, ME ^ 5'h01, 5'h1f, 16'h0000, q);
    chk("foreign_rd", 16'hffff, q);
  endtask : t_direct

  task automatic t_window;
    aim(FN_DATA, DEV_VENDOR, 16'h0021);
    chk("ptr", 16'h0021, pointer_value);
    put(REG_WINDOW, 16'h1234);
    get(REG_WINDOW);
    chk("data", 16'h1234, q);
    chk("ptr", 16'h0021, pointer_value);
    put(REG_CTRL, {FN_DATA_INC, 9'h0, DEV_VENDOR});
    get(REG_WINDOW);
    chk("ptr", 16'h0022, pointer_value);
    put(REG_WINDOW, 16'h5678);
    chk("ptr", 16'h0023, pointer_value);
    put(REG_CTRL, {FN_DATA_INC_WR, 9'h0, DEV_VENDOR});
    get(REG_WINDOW);
    chk("ptr", 16'h0023, pointer_value);
    put(REG_WINDOW, 16'h9abc);
    chk("ptr", 16'h0024, pointer_value);
    aim(FN_ADDR, DEV_VENDOR, 16'h0022);
    get(REG_WINDOW);
    chk("ptr_rd", 16'h0022, q);
    put(REG_CTRL, {FN_DATA, 9'h0, DEV_VENDOR});
    get(REG_WINDOW);
    chk("data", 16'h5678, q);
    chk("ctrl", 16'h401f, ctrl_value);
    put(5'h05, 16'h5a5a);
    aim(FN_DATA, DEV_VENDOR, 16'h0005);
    get(REG_WINDOW);
    chk("alias", 16'h5a5a, q);
    aim(FN_DATA, DEV_VENDOR, {11'h0, REG_CTRL});
    put(REG_WINDOW, 16'h7777);
    chk("ctrl", 16'h401f, ctrl_value);
  endtask : t_window

  task automatic t_spaces;
    logic [4:0] sp [4] = '{DEV_EEE_A, DEV_EEE_B, DEV_VENDOR, 5'h02};
    foreach (sp[i]) begin
      aim(FN_DATA, sp[i], 16'h0030);
      put(REG_WINDOW, {11'h0c3, sp[i]});
      get(REG_WINDOW);
      chk("space", (i < 3) ? {11'h0c3, sp[i]} : 16'h0000, q);
    end
    chk("ptr", 16'h0030, pointer_value);
    put(REG_CTRL, {FN_DATA, 9'h0, DEV_VENDOR});
    get(REG_WINDOW);
    chk("space", {11'h0c3, DEV_VENDOR}, q);
  endtask : t_spaces

  initial begin
    reset_n = 1'b0;
    addr    = 2'h0;
    wdata   = 16'h0000;
    wr      = 1'b0;
    rd      = 1'b0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
    t_direct;
    t_window;
    t_spaces;
    report_and_stop;
  end
endmodule : testbench
